//--- fiber_repeater_link_diagnostics.sv
// Repeater, retiming and fiber diagnostics of a copper to fiber converter.
// Function
// - Supply LED steady once speed known, 1 Hz flash while autobaud unresolved.
// - Pulse TX and RX activity LEDs for traffic on electrical connector.
// - Light_on_idle_polarity idle default: optical transmitter emits light while idle.
// - Default maps logic 1 to light on; standard setting maps to off.
// - Standard polarity without mixed option uses echo evaluation for diagnostics.
// - Standard polarity with echo disabled gives no fiber diagnostics.
// - Classify each port's received power into four levels.
// - Critical level lights yellow only, opens relay, keeps forwarding.
// - Redundant ring mode disables a port at critical level.
// - Signal on any interface drives out on all others.
// - Electrical, rail, optical A, optional optical B interfaces.
// - Every forwarded bit is retimed, no accumulated distortion.
// - Echo-detected broken fiber switches path off, sets error, alarms.
// - Redundant ring mode keeps echo evaluation active in every setting.
// - Echo monitoring only during idle phases between transmissions.
`timescale 1ns/1ps

module fiber_repeater_link_diagnostics (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] bit_cycles,
    input wire logic rate_valid,
    input wire repeater_pkg::setting_t setting_pins,
    input wire logic elec_rx,
    input wire logic rail_rx,
    input wire logic [1:0] opt_rx,
    input wire logic [3:0] opt_power,
    output logic elec_tx,
    output logic elec_tx_oe,
    output logic rail_tx,
    output logic rail_tx_oe,
    output logic [1:0] opt_tx,
    output logic supply_indicator,
    output logic tx_activity_indicator,
    output logic rx_activity_indicator,
    output repeater_pkg::port_led_t led_a,
    output repeater_pkg::port_led_t led_b,
    output logic alarm_relay
);

    // ==================================================================
    // Power-up settings
    repeater_pkg::setting_t cfg;
    logic cfg_taken;

    // Settings are latched on the first clock after reset release and held.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg <= '0;
            cfg_taken <= 1'b0;
        end else if (!cfg_taken) begin
            cfg <= setting_pins;
            cfg_taken <= 1'b1;
        end
    end

    function automatic repeater_pkg::diag_mode_t diag_of(input repeater_pkg::setting_t s);
        if (s.redundancy)
            return repeater_pkg::DIAG_ECHO;
        else if (!s.normal_polarity_setting)
            return repeater_pkg::DIAG_POWER;
        else if (!s.echo_select_switch)
            return repeater_pkg::DIAG_ECHO;
        else
            return repeater_pkg::DIAG_NONE;
    endfunction : diag_of

    repeater_pkg::diag_mode_t mode;
    assign mode = diag_of(cfg);

    // Converts a line level to logical data and back; symmetric in both directions.
    function automatic logic pol(input logic v, input logic normal);
        return normal ? ~v : v;
    endfunction : pol

    // ==================================================================
    // Inputs in logical form
    logic [3:0] rx_logic;
    logic [3:0] port_en;
    always_comb begin
        rx_logic[repeater_pkg::ELEC] = elec_rx;
        rx_logic[repeater_pkg::RAIL] = rail_rx;
        rx_logic[repeater_pkg::OPT_A] = pol(opt_rx[0], cfg.normal_polarity_setting);
        rx_logic[repeater_pkg::OPT_B] = pol(opt_rx[1], cfg.normal_polarity_setting);
    end

    // ==================================================================
    // Retiming: the first interface to leave idle owns the bus until idle.
    repeater_pkg::rx_state_t state;
    logic [1:0] owner;
    logic [15:0] bit_cnt;
    logic [3:0] idle_cnt;
    logic out_bit;
    logic [3:0] active_low;
    always_comb begin
        for (int i = 0; i < 4; i++)
            active_low[i] = port_en[i] & ~rx_logic[i];
    end

    // Sampling at mid bit and driving a full bit keeps edge jitter from piling up.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= repeater_pkg::RX_IDLE;
            owner <= 2'h0;
            bit_cnt <= repeater_pkg::DIV_RESET;
            idle_cnt <= 4'h0;
            out_bit <= 1'b1;
        end else begin
            unique case (state)
                repeater_pkg::RX_IDLE: begin
                    out_bit <= 1'b1;
                    // Line polarity is only valid once the settings are latched; a start
                    // taken before that would forward a false frame right after reset.
                    if (cfg_taken && rate_valid && (active_low != 4'h0)) begin
                        state <= repeater_pkg::RX_BITS;
                        bit_cnt <= {1'b0, bit_cycles[15:1]};
                        idle_cnt <= 4'h0;
                        for (int i = 3; i >= 0; i--)
                            if (active_low[i])
                                owner <= 2'(i);
                    end
                end
                repeater_pkg::RX_BITS: begin
                    if (bit_cnt == 16'h0000) begin
                        bit_cnt <= bit_cycles - 16'h0001;
                        out_bit <= rx_logic[owner];
                        if (rx_logic[owner])
                            idle_cnt <= idle_cnt + 4'h1;
                        else
                            idle_cnt <= 4'h0;
                        if (rx_logic[owner] && idle_cnt == 4'(repeater_pkg::IDLE_BITS - 1))
                            state <= repeater_pkg::RX_HOLD;
                    end else begin
                        bit_cnt <= bit_cnt - 16'h0001;
                    end
                end
                repeater_pkg::RX_HOLD: begin
                    // Hold for a full bit time so the last idle bit reaches full width.
                    if (bit_cnt == 16'h0000)
                        state <= repeater_pkg::RX_IDLE;
                    else
                        bit_cnt <= bit_cnt - 16'h0001;
                end
                default: state <= repeater_pkg::RX_IDLE;
            endcase
        end
    end

    logic busy;
    assign busy = (state != repeater_pkg::RX_IDLE);

    // Every enabled interface except the source gets the regenerated bit.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            elec_tx <= 1'b1;
            elec_tx_oe <= 1'b0;
            rail_tx <= 1'b1;
            rail_tx_oe <= 1'b0;
            opt_tx <= 2'h0;
        end else begin
            elec_tx <= out_bit;
            elec_tx_oe <= busy && owner != 2'(repeater_pkg::ELEC);
            rail_tx <= out_bit;
            rail_tx_oe <= busy && owner != 2'(repeater_pkg::RAIL);
            // Idle stays logic 1, so the light_on_idle_polarity setting keeps light on.
            opt_tx[0] <= port_en[repeater_pkg::OPT_A]
                && pol((busy && owner != 2'(repeater_pkg::OPT_A)) ? out_bit : 1'b1,
                       cfg.normal_polarity_setting);
            opt_tx[1] <= port_en[repeater_pkg::OPT_B] && cfg.port_b_present
                && pol((busy && owner != 2'(repeater_pkg::OPT_B)) ? out_bit : 1'b1,
                       cfg.normal_polarity_setting);
        end
    end

    // ==================================================================
    // Echo evaluation: while idle, each optical input must show logic 1 within ECHO_WAIT_CYCLES.
    logic [1:0] echo_broken;
    logic [11:0] echo_cnt;
    logic [1:0] echo_seen;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            echo_cnt <= 12'h000;
            echo_seen <= 2'h0;
            echo_broken <= 2'h0;
        end else if (mode != repeater_pkg::DIAG_ECHO || busy) begin
            echo_cnt <= 12'h000;
            echo_seen <= 2'h0;
        end else begin
            echo_seen <= echo_seen
                | {rx_logic[repeater_pkg::OPT_B], rx_logic[repeater_pkg::OPT_A]};
            if (echo_cnt == 12'(repeater_pkg::ECHO_WAIT_CYCLES - 1)) begin
                echo_cnt <= 12'h000;
                echo_broken <= ~(echo_seen | {rx_logic[3], rx_logic[2]});
                echo_seen <= 2'h0;
            end else begin
                echo_cnt <= echo_cnt + 12'h001;
            end
        end
    end

    // ==================================================================
    // Power levels and port shutdown
    function automatic repeater_pkg::level_t lvl(input logic [1:0] p);
        unique case (p)
            2'h0: return repeater_pkg::LVL_VERY_GOOD;
            2'h1: return repeater_pkg::LVL_GOOD;
            2'h2: return repeater_pkg::LVL_CRITICAL;
            default: return repeater_pkg::LVL_BROKEN;
        endcase
    endfunction : lvl

    repeater_pkg::level_t lv [2];
    assign lv[0] = lvl(opt_power[1:0]);
    assign lv[1] = lvl(opt_power[3:2]);

    function automatic repeater_pkg::port_led_t leds(input repeater_pkg::level_t l,
                                                      input logic on, input logic echo_err);
        repeater_pkg::port_led_t r;
        r = '0;
        if (on) begin
            unique case (l)
                repeater_pkg::LVL_VERY_GOOD: r.optical_level_bargraph = 3'h7;
                repeater_pkg::LVL_GOOD: r.optical_level_bargraph = 3'h6;
                repeater_pkg::LVL_CRITICAL: r.optical_level_bargraph = 3'h4;
                repeater_pkg::LVL_BROKEN: r.error = 1'b1;
            endcase
        end
        if (echo_err)
            r.error = 1'b1;
        return r;
    endfunction : leds

    logic [1:0] bad;
    logic [1:0] present;
    assign present = {cfg.port_b_present, 1'b1};
    always_comb begin
        for (int i = 0; i < 2; i++)
            bad[i] = present[i] && ((mode == repeater_pkg::DIAG_POWER
                && (lv[i] == repeater_pkg::LVL_CRITICAL || lv[i] == repeater_pkg::LVL_BROKEN))
                || echo_broken[i]);
    end

    always_comb begin
        port_en[repeater_pkg::ELEC] = 1'b1;
        port_en[repeater_pkg::RAIL] = 1'b1;
        for (int i = 0; i < 2; i++)
            port_en[2 + i] = present[i] && !echo_broken[i]
                && !(cfg.redundancy && lv[i] != repeater_pkg::LVL_VERY_GOOD
                     && lv[i] != repeater_pkg::LVL_GOOD);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            led_a <= '0;
            led_b <= '0;
            alarm_relay <= 1'b0;
        end else begin
            led_a <= leds(lv[0], cfg_taken && mode == repeater_pkg::DIAG_POWER,
                          echo_broken[0]);
            led_b <= leds(lv[1], cfg_taken && mode == repeater_pkg::DIAG_POWER && present[1],
                          echo_broken[1]);
            // Relay energised means healthy; drops open on critical or broken.
            alarm_relay <= cfg_taken && (bad == 2'h0);
        end
    end

    // ==================================================================
    // Indicators
    logic [25:0] blink_cnt;
    logic blink;
    logic [22:0] tx_hold;
    logic [22:0] rx_hold;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            blink_cnt <= 26'h0;
            blink <= 1'b0;
        end else if (blink_cnt == 26'(repeater_pkg::BLINK_HALF_CYCLES - 1)) begin
            blink_cnt <= 26'h0;
            blink <= ~blink;
        end else begin
            blink_cnt <= blink_cnt + 26'h1;
        end
    end

    // Activity is stretched so short frames remain visible.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_hold <= 23'h0;
            rx_hold <= 23'h0;
            supply_indicator <= 1'b0;
            tx_activity_indicator <= 1'b0;
            rx_activity_indicator <= 1'b0;
        end else begin
            supply_indicator <= rate_valid ? 1'b1 : blink;
            if (busy && owner != 2'(repeater_pkg::ELEC))
                tx_hold <= 23'(repeater_pkg::ACT_PULSE_CYCLES);
            else if (tx_hold != 23'h0)
                tx_hold <= tx_hold - 23'h1;
            if (busy && owner == 2'(repeater_pkg::ELEC))
                rx_hold <= 23'(repeater_pkg::ACT_PULSE_CYCLES);
            else if (rx_hold != 23'h0)
                rx_hold <= rx_hold - 23'h1;
            tx_activity_indicator <= tx_hold != 23'h0;
            rx_activity_indicator <= rx_hold != 23'h0;
        end
    end

endmodule : fiber_repeater_link_diagnostics

//--- repeater_pkg.sv
// Package with constants and carrier types of the fiber repeater diagnostics block.
package repeater_pkg;

    // ==================================================================
    // Timing
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned BLINK_HZ = 1;
    localparam int unsigned BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);
    localparam int unsigned ACT_PULSE_NS = 50_000_000;
    localparam int unsigned ACT_PULSE_CYCLES = ACT_PULSE_NS / 8;
    localparam int unsigned ECHO_WAIT_CYCLES = 2000;
    localparam int unsigned IDLE_BITS = 11;

    // ==================================================================
    // Widths and reset values
    localparam int unsigned NPORT = 4;
    localparam int unsigned ELEC = 0;
    localparam int unsigned RAIL = 1;
    localparam int unsigned OPT_A = 2;
    localparam int unsigned OPT_B = 3;
    localparam logic [1:0] LEVEL_RESET = 2'h0;
    localparam logic [15:0] DIV_RESET = 16'h0000;

    // ==================================================================
    // Received power levels.
    typedef enum logic [1:0] {
        LVL_VERY_GOOD = 2'h0,
        LVL_GOOD = 2'h1,
        LVL_CRITICAL = 2'h3,
        LVL_BROKEN = 2'h2
    } level_t;

    typedef enum logic [1:0] {
        DIAG_POWER = 2'h0,
        DIAG_ECHO = 2'h1,
        DIAG_NONE = 2'h3
    } diag_mode_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_BITS = 2'h1,
        RX_HOLD = 2'h3
    } rx_state_t;

    // Power-up settings.
    typedef struct packed {
        logic normal_polarity_setting;
        logic echo_select_switch;
        logic redundancy;
        logic port_b_present;
    } setting_t;

    // Per optical port LEDs.
    typedef struct packed {
        logic [2:0] optical_level_bargraph;
        logic error;
    } port_led_t;

endpackage : repeater_pkg

//--- peer_converter.sv
// Behavioural model of the far fiber converter that feeds optical port A.
`timescale 1ns/1ps
module peer_converter (
    input wire logic clk,
    input wire logic [15:0] bit_cycles,
    input wire logic light_off_idle,
    output logic line
);
    // ==================================================================
    // Character sender.
    logic level = 1'b1;
    // Logic 1 is the idle level; the flag must match the device's setting.
    assign line = level ^ light_off_idle;
    task automatic send_char(input logic [7:0] d);
        logic [10:0] fr;
        fr = {1'b1, ^d, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            #1 level = fr[i];
            repeat (bit_cycles - 16'h0001) @(posedge clk);
        end
    endtask : send_char
endmodule : peer_converter

//--- diag_checker.sv
// Port-level assertions for the fiber repeater diagnostics block.
`timescale 1ns/1ps
module diag_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] bit_cycles,
    input wire logic rate_valid,
    input wire logic elec_rx,
    input wire logic elec_tx_oe,
    input wire logic rail_tx,
    input wire logic rail_tx_oe,
    input wire logic supply_indicator,
    input wire logic tx_activity_indicator,
    input wire logic rx_activity_indicator,
    input wire repeater_pkg::port_led_t led_a,
    input wire repeater_pkg::port_led_t led_b,
    input wire logic alarm_relay
);
    logic prev_tx;
    logic prev_oe;
    logic [15:0] run;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // ==================================================================
    // Age of the rail bit, so that a shortened regenerated bit is caught.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_tx <= 1'b1;
            prev_oe <= 1'b0;
            run <= 16'h0000;
        end else begin
            prev_tx <= rail_tx;
            prev_oe <= rail_tx_oe;
            run <= (rail_tx != prev_tx) ? 16'h0000 : run + 16'h0001;
        end
    end
    sequence s_start;
        $fell(elec_rx) && rate_valid && !rail_tx_oe && !elec_tx_oe;
    endsequence
    property p_supply;
        $past(rate_valid) && $past(resetn) |-> supply_indicator;
    endproperty
    a_supply: assert property (p_supply) else $error("supply not steady");
    property p_rx_act;
        $fell(elec_rx) && rate_valid |-> ##[1:4] rx_activity_indicator;
    endproperty
    a_rx_act: assert property (p_rx_act) else $error("rx activity missing");
    property p_tx_act;
        $rose(elec_tx_oe) |-> ##[0:3] tx_activity_indicator;
    endproperty
    a_tx_act: assert property (p_tx_act) else $error("tx activity missing");
    property p_forward;
        s_start |-> ##[2:40] rail_tx_oe;
    endproperty
    a_forward: assert property (p_forward) else $error("rail not driven");
    property p_no_echo;
        s_start |-> ##1 !elec_tx_oe [*8];
    endproperty
    a_no_echo: assert property (p_no_echo) else $error("source driven back");
    property p_relay_crit;
        (led_a.optical_level_bargraph == 3'h4 || led_a.error) [*3] |-> !alarm_relay;
    endproperty
    a_relay_crit: assert property (p_relay_crit) else $error("relay not open");
    property p_relay_ok;
        (led_a.optical_level_bargraph == 3'h7 && led_b.optical_level_bargraph == 3'h7) [*3]
            |-> alarm_relay;
    endproperty
    a_relay_ok: assert property (p_relay_ok) else $error("relay not closed");
    property p_width;
        rail_tx != prev_tx && rail_tx_oe && prev_oe |-> run >= bit_cycles - 16'h0001;
    endproperty
    a_width: assert property (p_width) else $error("bit shortened");
    c_frame: cover property ($rose(rail_tx_oe));
    c_alarm: cover property ($fell(alarm_relay));
    c_tx: cover property ($rose(tx_activity_indicator));
endmodule : diag_checker
bind fiber_repeater_link_diagnostics diag_checker i_diag_checker (.clk(clk), .resetn(resetn),
    .bit_cycles(bit_cycles), .rate_valid(rate_valid), .elec_rx(elec_rx),
    .elec_tx_oe(elec_tx_oe), .rail_tx(rail_tx), .rail_tx_oe(rail_tx_oe),
    .supply_indicator(supply_indicator), .tx_activity_indicator(tx_activity_indicator),
    .rx_activity_indicator(rx_activity_indicator), .led_a(led_a), .led_b(led_b),
    .alarm_relay(alarm_relay));

//--- fiber_repeater_link_diagnostics_tb.sv
// Self-checking testbench of the fiber repeater diagnostics block.
`timescale 1ns/1ps
module fiber_repeater_link_diagnostics_tb;
    localparam logic [15:0] BITC = 16'h0008;
    logic clk, resetn, rate_valid, elec_rx, rail_rx, peer_pol, peer_line;
    logic [1:0] opt_rx;
    logic [3:0] opt_power;
    repeater_pkg::setting_t setting_pins;
    logic elec_tx, elec_tx_oe, rail_tx, rail_tx_oe, supply_indicator, alarm_relay;
    logic [1:0] opt_tx;
    logic tx_act, rx_act;
    repeater_pkg::port_led_t led_a, led_b;
    int bad_count, checks_done, cycles;
    logic [2:0] exp_bar [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
    // Port B's far end just idles at the same polarity as port A's peer.
    assign opt_rx = {~peer_pol, peer_line};
    fiber_repeater_link_diagnostics i_fiber_repeater_link_diagnostics (.clk(clk),
        .resetn(resetn), .bit_cycles(BITC), .rate_valid(rate_valid),
        .setting_pins(setting_pins), .elec_rx(elec_rx), .rail_rx(rail_rx), .opt_rx(opt_rx),
        .opt_power(opt_power), .elec_tx(elec_tx), .elec_tx_oe(elec_tx_oe), .rail_tx(rail_tx),
        .rail_tx_oe(rail_tx_oe), .opt_tx(opt_tx), .supply_indicator(supply_indicator),
        .tx_activity_indicator(tx_act), .rx_activity_indicator(rx_act), .led_a(led_a),
        .led_b(led_b), .alarm_relay(alarm_relay));
    peer_converter i_peer_converter (.clk(clk), .bit_cycles(BITC),
        .light_off_idle(peer_pol), .line(peer_line));
    // ==================================================================
    // Shared tasks.
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    function automatic logic [10:0] mk(input logic [7:0] d);
        return {1'b1, ^d, d, 1'b0};
    endfunction : mk
    function automatic logic pick(input int sel);
        case (sel)
            0: return rail_tx;
            1: return elec_tx;
            2: return opt_tx[0];
            default: return opt_tx[1];
        endcase
    endfunction : pick
    // Waits for a start bit, then samples each bit in its middle.
    task automatic watch(input int sel, input logic [10:0] fr);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #2 n++;
        end while (pick(sel) !== 1'b0 && n < 200);
        repeat (4) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            #2 check($sformatf("line %0d bit %0d", sel, i),
                {15'h0, fr[i]}, {15'h0, pick(sel)});
            repeat (BITC) @(posedge clk);
        end
        repeat (150) @(posedge clk);
        #1;
    endtask : watch
    task automatic send_elec(input logic [10:0] fr);
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            #1 elec_rx = fr[i];
            repeat (BITC - 16'h0001) @(posedge clk);
        end
    endtask : send_elec
    task automatic do_reset(input repeater_pkg::setting_t s);
        resetn = 1'b0;
        setting_pins = s;
        repeat (20) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask : do_reset
    task automatic report_and_stop();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    // ==================================================================
    // Clock, watchdog and test sequence.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        {rate_valid, elec_rx, rail_rx, peer_pol, opt_power} = {4'hE, 4'h0};
        do_reset(4'h1);
        check("opt idle", 16'h0003, {14'h0, opt_tx});
        check("supply", 16'h0001, {15'h0, supply_indicator});
        fork
            send_elec(mk(8'hA5));
            watch(0, mk(8'hA5));
            watch(2, mk(8'hA5));
            watch(3, mk(8'hA5));
        join
        check("rx act", 16'h0001, {15'h0, rx_act});
        check("tx act", 16'h0000, {15'h0, tx_act});
        fork
            i_peer_converter.send_char(8'h3C);
            watch(1, mk(8'h3C));
            watch(0, mk(8'h3C));
            watch(2, 11'h7FF);
        join
        check("tx act", 16'h0001, {15'h0, tx_act});
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1 opt_power = {2'h0, i[1:0]};
            repeat (6) @(posedge clk);
            #2 check("bar A", {13'h0, exp_bar[i]}, {13'h0, led_a.optical_level_bargraph});
            check("err A", {15'h0, i == 3}, {15'h0, led_a.error});
            check("relay", {15'h0, i < 2}, {15'h0, alarm_relay});
        end
        @(posedge clk);
        #1 opt_power = 4'h2;
        fork
            send_elec(mk(8'h96));
            watch(2, mk(8'h96));
        join
        do_reset(4'h3);
        // Later setting changes must not reach the running device.
        setting_pins = 4'h1;
        fork
            send_elec(mk(8'h5A));
            watch(2, 11'h000);
            watch(3, mk(8'h5A));
        join
        {peer_pol, opt_power} = 5'h1F;
        do_reset(4'hD);
        check("opt idle dark", 16'h0000, {14'h0, opt_tx});
        check("led A", 16'h0000, {12'h0, led_a});
        check("relay", 16'h0001, {15'h0, alarm_relay});
        fork
            i_peer_converter.send_char(8'hC3);
            watch(1, mk(8'hC3));
        join
        // Echo replaces power evaluation, so a broken power class must raise nothing.
        do_reset(4'h9);
        repeat (2100) @(posedge clk);
        #1 rate_valid = 1'b0;
        check("led A echo", 16'h0000, {12'h0, led_a});
        check("relay echo", 16'h0001, {15'h0, alarm_relay});
        repeat (2) @(posedge clk);
        // The flash starts in its dark half after reset.
        #2 check("supply flash", 16'h0000, {15'h0, supply_indicator});
        report_and_stop();
    end
endmodule : fiber_repeater_link_diagnostics_tb
